//--- rtl/dsc_capture.sv
// double-data-rate sram input capture, write store and two-beat read
// Functional notes
// - data sampled on both input clock edges
// - write starts when write select low
// - deselected write port ignores data, no write
// - only selected bytes of beat written
// - select n governs nine-bit lane n
// - byte select captured with its beat
// - read address on k, write on k-bar
// - 19 address bits narrow, 18 wide
// - address ignored when its port deselected
// - read select starts two-beat burst, then tristate
module dsc_capture
    import dsc_pkg::*;
#(
    parameter int WIDTH = WORD_W_NARROW,
    parameter int ADDR_W = (WIDTH == WORD_W_WIDE) ? ADDR_W_WIDE : ADDR_W_NARROW
)
(
    input wire logic mclk_i,                              // 10 MHz system clock
    input wire logic rst_b_i,                             // async reset, active low
    input wire logic k_edge_i,                            // this cycle is a k rising edge
    input wire logic kb_edge_i,                           // this cycle is a k-bar rising edge
    input wire logic write_port_select_n_i,               // write port select, active low
    input wire logic read_port_select_n_i,                // read port select, active low
    input wire logic [WIDTH/LANE_W-1:0] byte_write_select_n_i, // lane selects, active low
    input wire logic [ADDR_W-1:0] addr_i,                 // shared read/write address
    input wire logic [WIDTH-1:0] data_i,                  // write data
    output logic [WIDTH-1:0] q_o,                         // read data
    output logic q_oe_o,                                  // read data driven
    output logic write_done_o                             // pulse: burst stored
);

    localparam int LANES = WIDTH / LANE_W;
    localparam int DEPTH = 1 << (ADDR_W + 1);

    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    logic [WIDTH-1:0] mem [DEPTH];
    dsc_wstate_type wstate;
    dsc_rstate_type rstate;
    dsc_beat_type beat0;
    dsc_beat_type beat1;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] rd_addr;
    logic write_go;
    logic read_go;
    dsc_word_type sel_mask;
    dsc_word_type beat0_mask;

    assign write_go = k_edge_i && !write_port_select_n_i;
    assign read_go = k_edge_i && !read_port_select_n_i;
    assign sel_mask = dsc_lane_mask(dsc_sel_type'(byte_write_select_n_i));
    assign beat0_mask = dsc_lane_mask(beat0.sel_n);

    // ------------------------------------------------------------
    // write port
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wstate <= W_IDLE;
        end
        else
        begin
            unique case (wstate)
                W_IDLE:
                begin
                    if (write_go)
                    begin
                        wstate <= W_BEAT0;
                    end
                end
                W_BEAT0:
                begin
                    if (kb_edge_i)
                    begin
                        wstate <= W_IDLE;
                    end
                end
            endcase
        end
    end

    // first beat and its selects on k, second beat and address on k-bar
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            beat0 <= '{data: WORD_RESET, sel_n: SEL_N_RESET};
            beat1 <= '{data: WORD_RESET, sel_n: SEL_N_RESET};
            wr_addr <= '0;
        end
        else if (wstate == W_IDLE && write_go)
        begin
            beat0.data <= dsc_word_type'(data_i);
            beat0.sel_n <= dsc_sel_type'(~(~byte_write_select_n_i));
        end
        else if (wstate == W_BEAT0 && kb_edge_i)
        begin
            beat1.data <= dsc_word_type'(data_i);
            beat1.sel_n <= dsc_sel_type'(byte_write_select_n_i);
            wr_addr <= addr_i;
        end
    end

    // both beats land together, each under its own lane mask
    always_ff @(posedge mclk_i)
    begin
        if (wstate == W_BEAT0 && kb_edge_i)
        begin
            for (int b = 0; b < WIDTH; b++)
            begin
                if (beat0_mask[b])
                begin
                    mem[{addr_i, BEAT_FIRST}][b] <= beat0.data[b];
                end
                if (sel_mask[b])
                begin
                    mem[{addr_i, BEAT_SECOND}][b] <= data_i[b];
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            write_done_o <= 1'b0;
        end
        else
        begin
            write_done_o <= (wstate == W_BEAT0) && kb_edge_i;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rstate <= R_IDLE;
            rd_addr <= '0;
            q_o <= '0;
            q_oe_o <= 1'b0;
        end
        else
        begin
            unique case (rstate)
                R_IDLE, R_WORD1:
                begin
                    if (read_go)
                    begin
                        rd_addr <= addr_i;
                        rstate <= R_ADDR;
                    end
                    else if (kb_edge_i)
                    begin
                        q_oe_o <= 1'b0;
                        rstate <= R_IDLE;
                    end
                end
                R_ADDR:
                begin
                    if (kb_edge_i)
                    begin
                        q_o <= mem[{rd_addr, BEAT_FIRST}];
                        q_oe_o <= 1'b1;
                        rstate <= R_WORD0;
                    end
                end
                R_WORD0:
                begin
                    if (k_edge_i)
                    begin
                        q_o <= mem[{rd_addr, BEAT_SECOND}];
                        if (!read_port_select_n_i)
                        begin
                            rd_addr <= addr_i;
                            rstate <= R_ADDR;
                        end
                        else
                        begin
                            rstate <= R_WORD1;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    property p_wr_start;
        wstate == W_IDLE && k_edge_i && !write_port_select_n_i |=> wstate == W_BEAT0;
    endproperty
    a_wr_start: assert property (p_wr_start) else $error("write not started");

    property p_wr_deselect;
        wstate == W_IDLE && k_edge_i && write_port_select_n_i |=> wstate == W_IDLE ##1 !write_done_o;
    endproperty
    a_wr_deselect: assert property (p_wr_deselect) else $error("deselected write ran");

    property p_wr_done;
        wstate == W_BEAT0 && kb_edge_i |=> write_done_o && wr_addr == $past(addr_i);
    endproperty
    a_wr_done: assert property (p_wr_done) else $error("write burst not stored");

    property p_beat0_data;
        wstate == W_IDLE && write_go |=> beat0.data[WIDTH-1:0] == $past(data_i)
            && beat0.sel_n[LANES-1:0] == $past(byte_write_select_n_i);
    endproperty
    a_beat0_data: assert property (p_beat0_data) else $error("first beat lost");

    property p_lane0_word0;
        write_done_o && !beat0.sel_n[0] |-> mem[{wr_addr, BEAT_FIRST}][LANE_W-1:0] == beat0.data[LANE_W-1:0];
    endproperty
    a_lane0_word0: assert property (p_lane0_word0) else $error("first word lane 0 wrong");

    property p_lane1_word1;
        write_done_o && !beat1.sel_n[1]
            |-> mem[{wr_addr, BEAT_SECOND}][2*LANE_W-1:LANE_W] == beat1.data[2*LANE_W-1:LANE_W];
    endproperty
    a_lane1_word1: assert property (p_lane1_word1) else $error("second word lane 1 wrong");

    property p_addr_hold;
        wstate == W_IDLE |=> $stable(wr_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("idle write address moved");

    property p_rd_burst;
        (rstate == R_IDLE || rstate == R_WORD1) && read_go |=> rstate == R_ADDR && rd_addr == $past(addr_i);
    endproperty
    a_rd_burst: assert property (p_rd_burst) else $error("read burst not started");

    property p_rd_oe;
        rstate == R_ADDR && kb_edge_i |=> q_oe_o && rstate == R_WORD0
            && q_o == $past(mem[{rd_addr, BEAT_FIRST}]);
    endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("read word 0 not driven");

    property p_rd_off;
        rstate == R_WORD1 && kb_edge_i && !read_go |=> !q_oe_o && rstate == R_IDLE;
    endproperty
    a_rd_off: assert property (p_rd_off) else $error("read outputs not released");

    property p_byte_mask;
        wstate == W_BEAT0 && kb_edge_i && byte_write_select_n_i[0]
            |=> mem[{wr_addr, BEAT_SECOND}][LANE_W-1:0] == $past(mem[{addr_i, BEAT_SECOND}][LANE_W-1:0]);
    endproperty
    a_byte_mask: assert property (p_byte_mask) else $error("masked lane altered");

    c_write: cover property (write_done_o);
    c_read_burst: cover property (rstate == R_WORD0 && k_edge_i && read_port_select_n_i);
    c_back_to_back: cover property (rstate == R_WORD0 && read_go);
    c_masked: cover property (write_done_o && beat1.sel_n[0]);

endmodule : dsc_capture

//--- rtl/dsc_pkg.sv
// constants, types and lane helpers for the ddr sram input capture block
package dsc_pkg;

    // ------------------------------------------------------------
    // data and lane geometry
    // ------------------------------------------------------------
    localparam int WORD_W_NARROW = 18;
    localparam int WORD_W_WIDE = 36;
    localparam int WORD_W_MAX = WORD_W_WIDE;
    localparam int LANE_W = 9;
    localparam int LANES_MAX = WORD_W_MAX / LANE_W;
    localparam int ADDR_W_NARROW = 19;
    localparam int ADDR_W_WIDE = 18;
    localparam int BURST_LEN = 2;

    // ------------------------------------------------------------
    // reset values and beat address bit values
    // ------------------------------------------------------------
    localparam logic [WORD_W_MAX-1:0] WORD_RESET = 36'h0_0000_0000;
    localparam logic [LANES_MAX-1:0] SEL_N_RESET = 4'hF;
    localparam logic BEAT_FIRST = 1'b0;
    localparam logic BEAT_SECOND = 1'b1;

    typedef logic [WORD_W_MAX-1:0] dsc_word_type;
    typedef logic [LANES_MAX-1:0] dsc_sel_type;

    // one captured data beat with its lane selects
    typedef struct packed {
        dsc_word_type data;
        dsc_sel_type sel_n;
    } dsc_beat_type;

    typedef enum logic {
        W_IDLE = 1'b0,
        W_BEAT0 = 1'b1
    } dsc_wstate_type;

    typedef enum logic [1:0] {
        R_IDLE = 2'b00,
        R_ADDR = 2'b01,
        R_WORD0 = 2'b11,
        R_WORD1 = 2'b10
    } dsc_rstate_type;

    // active-low lane selects to a per-bit write enable
    function automatic dsc_word_type dsc_lane_mask(input dsc_sel_type sel_n);
        dsc_word_type m;
        m = WORD_RESET;
        for (int l = 0; l < LANES_MAX; l++)
        begin
            m[l*LANE_W +: LANE_W] = {LANE_W{~sel_n[l]}};
        end
        return m;
    endfunction : dsc_lane_mask

endpackage : dsc_pkg

//--- tb/dsc_ctrl.sv
// memory controller model: drives strobes, selects, address and data
module dsc_ctrl
    import dsc_pkg::*;
(
    input wire logic mclk_i,                    // system clock
    output logic k_edge_o,                      // k edge strobe
    output logic kb_edge_o,                     // k-bar edge strobe
    output logic write_port_select_n_o,         // write select, active low
    output logic read_port_select_n_o,          // read select, active low
    output logic [1:0] byte_write_select_n_o,   // lane selects, active low
    output logic [18:0] addr_o,                 // shared address
    output logic [17:0] data_o                  // write data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        k_edge_o = 1'b0;
        kb_edge_o = 1'b0;
        write_port_select_n_o = 1'b1;
        read_port_select_n_o = 1'b1;
        byte_write_select_n_o = 2'h3;
        addr_o = 19'h0_0000;
        data_o = 18'h0_0000;
    end

    // one input clock edge; all held until the sampling edge
    task automatic half(input logic k, input logic w_n, input logic r_n, input logic [18:0] a,
                        input logic [17:0] d, input logic [1:0] s);
        k_edge_o = k;
        kb_edge_o = ~k;
        write_port_select_n_o = w_n;
        read_port_select_n_o = r_n;
        addr_o = a;
        data_o = d;
        byte_write_select_n_o = s;
        @(posedge mclk_i);
        #1;
    endtask : half
endmodule : dsc_ctrl

//--- tb/testbench.sv
// random write and read pairs checked against a behavioural memory
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import dsc_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic k_edge, kb_edge, wps_n, rps_n, q_oe, wdone, w, r, pend, wprev;
    logic [1:0] bws_n, s0, s1;
    logic [18:0] addr;
    logic [17:0] data, q, e0, e1, d0, d1;
    logic [17:0] m [16];
    logic [2:0] ra, wa;
    int err_count = 0;
    int checks_done = 0;
    integer seed = 22;

    dsc_ctrl i_ctl (.mclk_i(mclk_i), .k_edge_o(k_edge), .kb_edge_o(kb_edge),
        .write_port_select_n_o(wps_n), .read_port_select_n_o(rps_n),
        .byte_write_select_n_o(bws_n), .addr_o(addr), .data_o(data));
    dsc_capture #(.WIDTH(18)) i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .k_edge_i(k_edge),
        .kb_edge_i(kb_edge), .write_port_select_n_i(wps_n), .read_port_select_n_i(rps_n),
        .byte_write_select_n_i(bws_n), .addr_i(addr), .data_i(data), .q_o(q),
        .q_oe_o(q_oe), .write_done_o(wdone));

    initial
    begin
        forever #50 mclk_i = ~mclk_i;
    end

    task automatic chk_word(input logic [17:0] exp);
        checks_done++;
        if (q !== exp)
        begin
            err_count++;
            $display("BAD %0t read data %h expected %h", $time, q, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag

    task automatic conclude;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    // one k / k-bar pair; junk on address and data where deselected
    task automatic pair;
        if (pend)
            chk_word(e0);
        chk_flag(q_oe, pend);
        chk_flag(wdone, wprev);
        i_ctl.half(1'b1, ~w, ~r, r ? 19'(ra) : 19'($random(seed)), d0, s0);
        if (pend)
            chk_word(e1);
        chk_flag(q_oe, pend);
        chk_flag(wdone, 1'b0);
        e0 = m[{ra, 1'b0}];
        for (int l = 0; l < 2; l++)
        begin
            if (w && !s0[l])
                m[{wa, 1'b0}][l*9 +: 9] = d0[l*9 +: 9];
            if (w && !s1[l])
                m[{wa, 1'b1}][l*9 +: 9] = d1[l*9 +: 9];
        end
        e1 = m[{ra, 1'b1}];
        pend = r;
        wprev = w;
        i_ctl.half(1'b0, 1'b1, 1'b1, w ? 19'(wa) : 19'($random(seed)), d1, s1);
    endtask : pair

    initial
    begin
        pend = 1'b0;
        wprev = 1'b0;
        repeat (12) @(posedge mclk_i);
        chk_flag(q_oe, 1'b0);
        chk_word(18'h0_0000);
        #1 rst_b_i = 1'b1;
        for (int i = 0; i < 408; i++)
        begin
            w = (i < 8) ? 1'b1 : (i < 406) ? 1'($random(seed)) : 1'b0;
            r = (i < 8 || i >= 406) ? 1'b0 : 1'($random(seed));
            wa = (i < 8) ? 3'(i) : 3'($random(seed));
            ra = 3'($random(seed));
            d0 = 18'($random(seed));
            d1 = 18'($random(seed));
            s0 = (i < 8) ? 2'h0 : 2'($random(seed));
            s1 = (i < 8) ? 2'h0 : 2'($random(seed));
            pair();
        end
        conclude();
    end

    initial
    begin
        repeat (5000) @(posedge mclk_i);
        err_count++;
        conclude();
    end
endmodule : testbench
